//--- verilog/sps_pkg.sv
// Package for the sensor power and reset sequencer (host side).
// Assumes a single 50 MHz clock domain.
package sps_pkg;
   localparam int unsigned CLOCK_MHZ          = 50;
   localparam int unsigned STEP_GAP_US        = 10;
   localparam int unsigned CORE_TO_IO_MIN_US  = 5;
   localparam int unsigned HARD_RESET_MS      = 1;
   localparam int unsigned INIT_REF_CLOCKS    = 150000;
   localparam int unsigned PLL_LOCK_MS        = 1;
   localparam int unsigned OFF_HOLD_MS        = 100;
   localparam int unsigned STEP_GAP_CYCLES    = STEP_GAP_US * CLOCK_MHZ;
   localparam int unsigned CORE_TO_IO_CYCLES  = CORE_TO_IO_MIN_US * CLOCK_MHZ;
   localparam int unsigned HARD_RESET_CYCLES  = HARD_RESET_MS * 1000 * CLOCK_MHZ;
   localparam int unsigned PLL_LOCK_CYCLES    = PLL_LOCK_MS * 1000 * CLOCK_MHZ;
   localparam int unsigned OFF_HOLD_CYCLES    = OFF_HOLD_MS * 1000 * CLOCK_MHZ;
   localparam int unsigned FRAME_CYCLES_DEF   = 2000000;
   localparam int unsigned REF_DIV_DEF        = 2;
   localparam logic [15:0] CTRL_REG_ADDR      = 16'h301A;
   localparam int unsigned STREAM_BIT         = 2;
   localparam logic [15:0] STREAM_ON_VALUE    = 16'h0004;
   localparam logic [15:0] STREAM_OFF_VALUE   = 16'h0000;

   typedef enum logic [3:0] {
      SPS_OFF, SPS_PLL_ON, SPS_ANALOG_ON, SPS_CORE_ON, SPS_IO_ON, SPS_SERIAL_ON,
      SPS_RESET_HOLD, SPS_INIT_WAIT, SPS_CONFIG, SPS_LOCK_WAIT, SPS_STREAM_REQ,
      SPS_STREAMING, SPS_STOP_REQ, SPS_DRAIN, SPS_RAILS_DOWN, SPS_OFF_HOLD
   } sps_state_type;

   typedef struct packed {
      logic pll;
      logic analog;
      logic pixel;
      logic core;
      logic io;
      logic serial;
   } sps_rails_type;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [15:0] data;
   } sps_write_type;
endpackage

//--- verilog/sps_sequencer.sv
// Host controller that powers up, resets, starts and shuts down an image sensor.
// Assumes a separate serial-write engine that takes write requests and answers done.
// How it works
// - The PLL rail is switched on first, before any other rail.
// - Rails come up PLL, analog/pixel, core, I/O, serial with 10 us gaps.
// - At least 5 us pass between core rail and I/O rail enable.
// - The reference clock starts only after the final rail is up.
// - Hard reset stays asserted 1 ms after rails and clock settle.
// - No configuration until 150,000 reference clocks after reset release.
// - Configuration runs, then 1 ms wait for PLL lock before streaming.
// - Streaming starts by writing one to bit 2 of register 0x301A.
// - Streaming bit is cleared before any rail is removed, except by a reset, which drops all rails at once.
// - Rails go down serial, I/O, core, analog/pixel, PLL.
// - All rails stay off at least 100 ms before the next power-up.
`timescale 1ns/1ns
`default_nettype none
module sps_sequencer
   import sps_pkg::*;
#(
   parameter int unsigned HARD_RESET_CYC = sps_pkg::HARD_RESET_CYCLES,
   parameter int unsigned INIT_REF_CYC   = sps_pkg::INIT_REF_CLOCKS,
   parameter int unsigned PLL_LOCK_CYC   = sps_pkg::PLL_LOCK_CYCLES,
   parameter int unsigned OFF_HOLD_CYC   = sps_pkg::OFF_HOLD_CYCLES,
   parameter int unsigned FRAME_CYC      = sps_pkg::FRAME_CYCLES_DEF,
   parameter int unsigned REF_DIV        = sps_pkg::REF_DIV_DEF
) (
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   input  wire logic                  clock_enable,
   input  wire logic                  power_request,
   input  wire logic                  serial_rail_used,
   input  wire logic                  config_done,
   input  wire logic                  write_done,
   output sps_pkg::sps_rails_type     rails,
   output logic                       input_reference_clock,
   output logic                       sensor_reset_n,
   output logic                       config_start,
   output sps_pkg::sps_write_type     write_request,
   output logic                       streaming,
   output logic                       powered_off
);
   import sps_pkg::*;

   typedef struct packed {
      sps_state_type state;
      sps_rails_type rails;
      logic [23:0]   count;
      logic [7:0]    div;
      logic          ref_clk;
      logic          ref_run;
      logic          rst_n;
      logic          cfg_start;
      sps_write_type wr;
      logic [1:0]    req_sync;
      logic [1:0]    cfg_sync;
      logic [1:0]    wd_sync;
   } sps_regs_type;

   // The core-to-I/O gap takes the larger of its own floor and the usual step gap
   localparam logic [23:0] GAP_C   = 24'(STEP_GAP_CYCLES);
   localparam logic [23:0] IO_C    = 24'((CORE_TO_IO_CYCLES > STEP_GAP_CYCLES) ?
                                         CORE_TO_IO_CYCLES : STEP_GAP_CYCLES);
   localparam logic [23:0] RST_C   = 24'(HARD_RESET_CYC);
   localparam logic [23:0] INIT_C  = 24'(INIT_REF_CYC);
   localparam logic [23:0] LOCK_C  = 24'(PLL_LOCK_CYC);
   localparam logic [23:0] HOLD_C  = 24'(OFF_HOLD_CYC);
   localparam logic [23:0] FRAME_C = 24'(FRAME_CYC);
   localparam logic [7:0]  DIV_C   = 8'(REF_DIV);

   sps_regs_type s_reg;
   sps_regs_type s_next;
   logic         req_s;
   logic         cfg_s;
   logic         wd_s;
   logic         ref_rise;

   // Only the second flop of each synchroniser is read
   assign req_s = s_reg.req_sync[1];
   assign cfg_s = s_reg.cfg_sync[1];
   assign wd_s  = s_reg.wd_sync[1];
   assign ref_rise = s_reg.ref_run && !s_reg.ref_clk && (s_reg.div == DIV_C - 8'h01);

   // One down-counter serves every timed step: a state loads it once and
   // waits for zero. Sharing it keeps the area small; the price is that no
   // two waits may overlap, which the sequence never needs.
   always_comb begin
      s_next = s_reg;
      s_next.req_sync = {s_reg.req_sync[0], power_request};
      s_next.cfg_sync = {s_reg.cfg_sync[0], config_done};
      s_next.wd_sync  = {s_reg.wd_sync[0], write_done};
      s_next.cfg_start = 1'b0;
      if (s_reg.count != 24'h000000) begin
         s_next.count = s_reg.count - 24'h000001;
      end

      // Reference clock divider, free running once started
      if (s_reg.ref_run) begin
         if (s_reg.div == DIV_C - 8'h01) begin
            s_next.div = 8'h00;
            s_next.ref_clk = !s_reg.ref_clk;
         end else begin
            s_next.div = s_reg.div + 8'h01;
         end
      end

      case (s_reg.state)
         // Also waits out the off hold left behind by a reset
         SPS_OFF: begin
            if (req_s && s_reg.count == 24'h000000) begin
               s_next.rails.pll = 1'b1;
               s_next.count = GAP_C;
               s_next.state = SPS_PLL_ON;
            end
         end

         // Analog and pixel rails share one step
         SPS_PLL_ON: begin
            if (s_reg.count == 24'h000000) begin
               s_next.rails.analog = 1'b1;
               s_next.rails.pixel = 1'b1;
               s_next.count = GAP_C;
               s_next.state = SPS_ANALOG_ON;
            end
         end

         SPS_ANALOG_ON: begin
            if (s_reg.count == 24'h000000) begin
               s_next.rails.core = 1'b1;
               s_next.count = IO_C;
               s_next.state = SPS_CORE_ON;
            end
         end

         // The longer gap suits either I/O rail voltage
         SPS_CORE_ON: begin
            if (s_reg.count == 24'h000000) begin
               s_next.rails.io = 1'b1;
               s_next.count = GAP_C;
               s_next.state = SPS_IO_ON;
            end
         end

         // An unused serial rail stays off, but its step time is still spent
         SPS_IO_ON: begin
            if (s_reg.count == 24'h000000) begin
               s_next.rails.serial = serial_rail_used;
               s_next.count = GAP_C;
               s_next.state = SPS_SERIAL_ON;
            end
         end

         // The step gap doubles as settle time for the last rail
         SPS_SERIAL_ON: begin
            if (s_reg.count == 24'h000000) begin
               s_next.ref_run = 1'b1;
               s_next.count = RST_C;
               s_next.state = SPS_RESET_HOLD;
            end
         end

         // Hard reset is timed from the start of the clock, after all rails
         SPS_RESET_HOLD: begin
            if (s_reg.count == 24'h000000) begin
               s_next.rst_n = 1'b1;
               s_next.count = INIT_C;
               s_next.state = SPS_INIT_WAIT;
            end
         end

         SPS_INIT_WAIT: begin
            // Counts are held to reference clock rising edges, not system cycles
            if (ref_rise && s_reg.count != 24'h000000) begin
               s_next.count = s_reg.count - 24'h000001;
            end else begin
               s_next.count = s_reg.count;
            end
            if (s_reg.count == 24'h000000) begin
               s_next.cfg_start = 1'b1;
               s_next.state = SPS_CONFIG;
            end
         end

         // Lock time starts only once the outside engine reports done
         SPS_CONFIG: begin
            if (cfg_s) begin
               s_next.count = LOCK_C;
               s_next.state = SPS_LOCK_WAIT;
            end
         end

         SPS_LOCK_WAIT: begin
            if (s_reg.count == 24'h000000) begin
               s_next.wr.valid = 1'b1;
               s_next.wr.addr = CTRL_REG_ADDR;
               s_next.wr.data = STREAM_ON_VALUE;
               s_next.state = SPS_STREAM_REQ;
            end
         end

         // The request stands until the synchronised done is seen
         SPS_STREAM_REQ: begin
            if (wd_s) begin
               s_next.wr.valid = 1'b0;
               s_next.state = SPS_STREAMING;
            end
         end

         // Done must fall first so the stop write is not taken as finished
         SPS_STREAMING: begin
            if (!req_s && !wd_s) begin
               s_next.wr.valid = 1'b1;
               s_next.wr.addr = CTRL_REG_ADDR;
               s_next.wr.data = STREAM_OFF_VALUE;
               s_next.state = SPS_STOP_REQ;
            end
         end

         SPS_STOP_REQ: begin
            if (wd_s) begin
               s_next.wr.valid = 1'b0;
               s_next.count = FRAME_C;
               s_next.state = SPS_DRAIN;
            end
         end

         // Standby entry is not signalled, so a whole frame time is spent
         SPS_DRAIN: begin
            if (s_reg.count == 24'h000000) begin
               s_next.rails.serial = 1'b0;
               s_next.ref_run = 1'b0;
               s_next.ref_clk = 1'b0;
               s_next.div = 8'h00;
               s_next.rst_n = 1'b0;
               s_next.state = SPS_RAILS_DOWN;
            end
         end

         SPS_RAILS_DOWN: begin
            // One step per cycle, analog and pixel together, reverse of power-up
            if (s_reg.rails.io) begin
               s_next.rails.io = 1'b0;
            end else if (s_reg.rails.core) begin
               s_next.rails.core = 1'b0;
            end else if (s_reg.rails.analog) begin
               s_next.rails.analog = 1'b0;
               s_next.rails.pixel = 1'b0;
            end else begin
               s_next.rails.pll = 1'b0;
               s_next.count = HOLD_C;
               s_next.state = SPS_OFF_HOLD;
            end
         end

         // A power request in this state waits for the hold to run out
         SPS_OFF_HOLD: begin
            if (s_reg.count == 24'h000000) begin
               s_next.state = SPS_OFF;
            end
         end

         default: begin
            s_next.state = SPS_OFF;
         end
      endcase
   end

   // A reset drops every rail at once, so the full off hold is owed again
   // before the next power-up; clock enable low freezes every register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_reg       <= '0;
         s_reg.count <= HOLD_C;
      end else if (clock_enable) begin
         s_reg <= s_next;
      end
   end

   // All outputs but the two state decodes come straight from flops
   assign rails = s_reg.rails;
   assign input_reference_clock = s_reg.ref_clk;
   assign sensor_reset_n = s_reg.rst_n;
   assign config_start = s_reg.cfg_start;
   assign write_request = s_reg.wr;
   assign streaming = (s_reg.state == SPS_STREAMING);
   assign powered_off = (s_reg.state == SPS_OFF);
endmodule
`default_nettype wire

//--- tb/sps_sequencer_chk.sv
// Port-level assertions for the sensor power and reset sequencer.
// Bound into every sps_sequencer; one clock domain, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module sps_sequencer_chk
   import sps_pkg::*;
#(
   parameter int unsigned HARD_RESET_CYC = 20,
   parameter int unsigned INIT_REF_CYC   = 10,
   parameter int unsigned PLL_LOCK_CYC   = 20,
   parameter int unsigned OFF_HOLD_CYC   = 50,
   parameter int unsigned FRAME_CYC      = 30
) (
   input wire logic                   clock,
   input wire logic                   reset_n,
   input wire logic                   clock_enable,
   input wire logic                   serial_rail_used,
   input wire sps_pkg::sps_rails_type rails,
   input wire logic                   input_reference_clock,
   input wire logic                   sensor_reset_n,
   input wire logic                   config_start,
   input wire sps_pkg::sps_write_type write_request
);
   logic [23:0] hold_reg, init_reg, lock_reg, drain_reg, off_reg;
   logic        ref_reg;
   // Off counter starts at zero: a reset cuts the rails, so a full hold is owed
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         {hold_reg, init_reg, lock_reg, drain_reg, ref_reg} <= '0;
         off_reg <= '0;
      end else if (clock_enable) begin
         ref_reg <= input_reference_clock;
         hold_reg <= (rails.io && !sensor_reset_n) ? hold_reg + 24'h000001 : '0;
         init_reg <= !sensor_reset_n ? '0 : init_reg + 24'(input_reference_clock && !ref_reg);
         lock_reg <= config_start ? '0 : lock_reg + 24'h000001;
         drain_reg <= (write_request.valid && write_request.data == STREAM_OFF_VALUE) ? '0 : drain_reg + 24'h000001;
         off_reg <= (|rails) ? '0 : off_reg + 24'(off_reg != '1);
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_tail;
      $fell(rails.analog) && !rails.pixel ##1 $fell(rails.pll);
   endsequence
   a_pll_first: assert property ((rails.analog | rails.pixel | rails.core | rails.io | rails.serial) |-> rails.pll)
      else $error("rail on while pll rail off");
   a_up_order: assert property ($rose(rails.core) |-> rails.analog && rails.pixel && !rails.io)
      else $error("core rail out of order");
   a_core_io_gap: assert property ($rose(rails.io) |-> $past(rails.core, 250))
      else $error("io rail too soon after core");
   a_clock_late: assert property ($rose(input_reference_clock) |-> rails.io && (rails.serial || !serial_rail_used))
      else $error("reference clock before rails");
   a_reset_hold: assert property ($rose(sensor_reset_n) |-> hold_reg >= HARD_RESET_CYC)
      else $error("hard reset released early");
   a_init_wait: assert property (config_start |-> init_reg >= INIT_REF_CYC)
      else $error("configuration before init");
   a_lock_wait: assert property ($rose(write_request.valid) && write_request.data == STREAM_ON_VALUE |-> lock_reg > PLL_LOCK_CYC)
      else $error("streaming before pll lock");
   a_write_target: assert property (write_request.valid |-> write_request.addr == CTRL_REG_ADDR)
      else $error("write to wrong register");
   a_frame_drain: assert property (($fell(rails.io) || $fell(rails.serial)) |-> drain_reg >= FRAME_CYC)
      else $error("rail removed before frame drained");
   a_down_order: assert property ($fell(rails.core) |-> !rails.io && !rails.serial ##1 s_tail)
      else $error("power-down order broken");
   a_off_hold: assert property ($rose(rails.pll) |-> off_reg >= OFF_HOLD_CYC)
      else $error("power-up inside off hold");
endmodule
bind sps_sequencer sps_sequencer_chk #(.HARD_RESET_CYC(HARD_RESET_CYC), .INIT_REF_CYC(INIT_REF_CYC),
   .PLL_LOCK_CYC(PLL_LOCK_CYC), .OFF_HOLD_CYC(OFF_HOLD_CYC), .FRAME_CYC(FRAME_CYC)) u_chk (
   .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable), .serial_rail_used(serial_rail_used),
   .rails(rails), .input_reference_clock(input_reference_clock), .sensor_reset_n(sensor_reset_n),
   .config_start(config_start), .write_request(write_request));
`default_nettype wire

//--- tb/sps_sensor_model.sv
// Behavioural sensor with its configuration and serial-write engines.
// Driven by the sequencer's rail, clock, reset and write outputs.
`timescale 1ns/1ns
`default_nettype none
module sps_sensor_model
   import sps_pkg::*;
#(
   parameter int unsigned INIT_REF_CYC = 10
) (
   input  wire logic                   clock,
   input  wire logic                   slow,
   input  wire sps_pkg::sps_rails_type rails,
   input  wire logic                   input_reference_clock,
   input  wire logic                   sensor_reset_n,
   input  wire logic                   config_start,
   input  wire sps_pkg::sps_write_type write_request,
   output logic                        config_done = 1'b0,
   output logic                        write_done = 1'b0,
   output logic                        active = 1'b0,
   output logic                        fault = 1'b0
);
   int   ref_cnt = 0, cfg_cnt = 0, wr_cnt = 0, frame_cnt = 0;
   logic stream_bit = 1'b0, ref_d = 1'b0;
   always @(posedge clock) begin
      ref_d <= input_reference_clock;
      ref_cnt <= !sensor_reset_n ? 0 : ref_cnt + int'(input_reference_clock && !ref_d);
      if ((|rails && !rails.pll) || (input_reference_clock && !rails.io) || (active && !rails.io))
         fault <= 1'b1;
      if ((config_start || write_request.valid) && ref_cnt < INIT_REF_CYC)
         fault <= 1'b1;
      cfg_cnt <= config_start ? (slow ? 40 : 3) : (cfg_cnt > 0 ? cfg_cnt - 1 : 0);
      config_done <= sensor_reset_n && !config_start && (config_done || cfg_cnt == 1);
      if (!write_request.valid) begin
         write_done <= 1'b0;
         wr_cnt <= 0;
      end else if (!write_done) begin
         wr_cnt <= wr_cnt + 1;
         if (wr_cnt == (slow ? 12 : 2)) begin
            write_done <= 1'b1;
            stream_bit <= write_request.data[STREAM_BIT];
         end
      end
      // A cleared stream bit takes effect only at the end of the frame
      frame_cnt <= (stream_bit || active) ? (frame_cnt + 1) % 8 : 0;
      if (frame_cnt == 7 || !active)
         active <= stream_bit;
   end
endmodule
`default_nettype wire

//--- tb/test_sps_sequencer.sv
// Self-checking bench for the sensor power and reset sequencer.
// Uses the behavioural sensor model and short timing parameters.
`timescale 1ns/1ns
`default_nettype none
module test_sps_sequencer;
   import sps_pkg::*;
   localparam int unsigned G = STEP_GAP_CYCLES + 1;
   logic          clock = 1'b0, reset_n = 1'b0, clock_enable = 1'b1, power_request = 1'b0;
   logic          serial_rail_used = 1'b1, slow = 1'b0;
   sps_rails_type rails;
   sps_write_type write_request;
   logic          input_reference_clock, sensor_reset_n, config_start, streaming, powered_off;
   logic          config_done, write_done, active, fault;
   int            err_count = 0, compares = 0, cyc = 0, t_off = 0;
   int            up[7], dn[7];
   logic [6:0]    mon, mon_d;
   assign mon = {rails.pll, rails.analog, rails.core, rails.io, rails.serial, sensor_reset_n, input_reference_clock};
   sps_sequencer #(.HARD_RESET_CYC(20), .INIT_REF_CYC(10), .PLL_LOCK_CYC(20), .OFF_HOLD_CYC(50), .FRAME_CYC(30))
      DUT (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
      .power_request(power_request), .serial_rail_used(serial_rail_used), .config_done(config_done),
      .write_done(write_done), .rails(rails), .input_reference_clock(input_reference_clock),
      .sensor_reset_n(sensor_reset_n), .config_start(config_start), .write_request(write_request),
      .streaming(streaming), .powered_off(powered_off));
   sps_sensor_model sensor (.clock(clock), .slow(slow), .rails(rails),
      .input_reference_clock(input_reference_clock), .sensor_reset_n(sensor_reset_n), .config_start(config_start),
      .write_request(write_request), .config_done(config_done), .write_done(write_done), .active(active),
      .fault(fault));
   always #10 clock = ~clock;
   // First edge of each watched output after the stamps were cleared
   always @(posedge clock) begin
      cyc <= cyc + 1;
      mon_d <= mon;
      for (int i = 0; i < 7; i++) begin
         if (mon[i] && !mon_d[i] && up[i] == 0) up[i] <= cyc;
         if (!mon[i] && mon_d[i] && dn[i] == 0) dn[i] <= cyc;
      end
      if (write_request.valid && write_request.data === STREAM_OFF_VALUE && t_off == 0) t_off <= cyc;
   end
   task automatic final_report();
      $display("Counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_for(input bit on);
      int n;
      n = 0;
      while ((on ? streaming : powered_off) !== 1'b1 && n < 20000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 20000) begin
         chk(n, 0);
         final_report();
      end
      #2;
   endtask
   task automatic t_power_up(input bit ser, input bit glitch);
      up = '{default: 0};
      serial_rail_used = ser;
      power_request = 1'b1;
      // A drop before streaming must be ignored
      if (glitch) begin
         repeat (600) @(posedge clock);
         #2 power_request = 1'b0;
         repeat (5) @(posedge clock);
         #2 power_request = 1'b1;
      end
      wait_for(1'b1);
      chk(up[5] - up[6], G);
      chk(up[4] - up[5], G);
      chk(up[3] - up[4], G);
      chk(ser ? up[2] - up[3] : 32'(rails.serial), ser ? G : 0);
      chk(up[0] > up[3] && (up[0] > up[2] || !ser), 1);
      chk(up[1] - up[3] >= 20, 1);
      if (dn[6] != 0) chk(up[6] - dn[6] >= 50, 1);
      chk({active, fault}, 2'b10);
      $display("power-up test done, serial rail %0d", ser);
   endtask
   task automatic t_power_down();
      dn = '{default: 0};
      t_off = 0;
      power_request = 1'b0;
      wait_for(1'b0);
      chk(t_off != 0 && dn[1] - t_off >= 30, 1);
      chk(dn[3] - dn[1], 1);
      chk(dn[4] - dn[3], 1);
      chk(dn[5] - dn[4], 1);
      chk(dn[6] - dn[5], 1);
      chk({active, fault, rails}, '0);
      $display("power-down test done");
   endtask
   // Reset in mid power-up: rails drop at once and a full off hold follows
   task automatic t_reset_mid();
      int t_rst;
      up = '{default: 0};
      power_request = 1'b1;
      repeat (700) @(posedge clock);
      #2 reset_n = 1'b0;
      #2 chk({powered_off, rails, sensor_reset_n}, 8'h80);
      repeat (2) @(posedge clock);
      #2 reset_n = 1'b1;
      t_rst = cyc;
      up = '{default: 0};
      wait_for(1'b1);
      chk(up[6] - t_rst >= 50, 1);
      chk({active, fault}, 2'b10);
      $display("mid-run reset test done");
   endtask
   // Clock enable low must freeze the block, a shutdown request included
   task automatic t_freeze();
      clock_enable = 1'b0;
      power_request = 1'b0;
      repeat (40) @(posedge clock);
      #2 chk({streaming, rails, sensor_reset_n}, 8'hFF);
      clock_enable = 1'b1;
      $display("clock enable freeze test done");
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #2 reset_n = 1'b1;
      chk({powered_off, rails}, 7'h40);
      t_power_up(1'b1, 1'b0);
      t_freeze();
      t_power_down();
      slow = 1'b1;
      t_power_up(1'b0, 1'b1);
      t_power_down();
      t_reset_mid();
      t_power_down();
      final_report();
   end
endmodule
`default_nettype wire
